// File: common/slcd_defs.svh
`ifndef SLCD_DEFS_SVH
`define SLCD_DEFS_SVH

// ----------------------------------------------------------------
// Register byte addresses on the bus
// ----------------------------------------------------------------
`define SLCD_ADDR_CTRL0 8'h00
`define SLCD_ADDR_CTRL1 8'h04
`define SLCD_ADDR_PTRH 8'h08
`define SLCD_ADDR_PTRL 8'h0C
`define SLCD_ADDR_DATA 8'h10
`define SLCD_ADDR_STAT 8'h14

// ----------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------
`define SLCD_CTRL0_RST 8'h00
`define SLCD_CTRL1_RST 8'h00
`define SLCD_CTRL0_MASK 8'hF7
`define SLCD_CTRL1_MASK 8'hEF
`define SLCD_CTRL1_WMASK 8'hEF

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SLCD_C0_EN 7
`define SLCD_C0_TYPE 6
`define SLCD_C0_DUTY 5
`define SLCD_C0_BIAS 4
`define SLCD_C1_QCT_LSB 5
`define SLCD_C1_VLCD_MSB 3

// ----------------------------------------------------------------
// Display window and pointer selection
// ----------------------------------------------------------------
`define SLCD_WIN_FIRST 8'h80
`define SLCD_WIN_LAST 8'h93
`define SLCD_PTRH_DISP 8'h01
`define SLCD_SEG_NUM 20
`define SLCD_VLCD_FULL 5'h10
`define SLCD_VLCD_BASE 5'h08

// ----------------------------------------------------------------
// Timing: sub clock periods per common slot
// ----------------------------------------------------------------
`define SLCD_COM_TICKS 16

`endif

// File: common/slcd_pkg.sv
package slcd_pkg;
    // Bus response codes
    typedef enum logic [1:0] {
        SLCD_RESP_OKAY = 2'h0,
        SLCD_RESP_SLVERR = 2'h2
    } slcd_resp_t;
    // Drive polarity of the panel waveform
    typedef enum logic {
        SLCD_POL_POS,
        SLCD_POL_NEG
    } slcd_pol_t;
endpackage

// File: verilog/slcd_sync.sv
`timescale 1ns/100ps
`default_nettype none
module slcd_sync (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic async_i,
    output logic sync_o
);
    logic meta_r;
    // Two stages; only the second is read by anyone
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_r <= 1'b0;
            sync_o <= 1'b0;
        end else begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end
endmodule
`default_nettype wire

// File: verilog/slcd_axil.sv
`timescale 1ns/100ps
`default_nettype none
module slcd_axil import slcd_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] s_awaddr_i,
    input wire logic s_awvalid_i,
    output logic s_awready_o,
    input wire logic [31:0] s_wdata_i,
    input wire logic [3:0] s_wstrb_i,
    input wire logic s_wvalid_i,
    output logic s_wready_o,
    output logic [1:0] s_bresp_o,
    output logic s_bvalid_o,
    input wire logic s_bready_i,
    input wire logic [7:0] s_araddr_i,
    input wire logic s_arvalid_i,
    output logic s_arready_o,
    output logic [31:0] s_rdata_o,
    output logic [1:0] s_rresp_o,
    output logic s_rvalid_o,
    input wire logic s_rready_i,
    output logic wr_o,
    output logic [7:0] wr_addr_o,
    output logic [7:0] wr_data_o,
    input wire logic wr_err_i,
    output logic [7:0] rd_addr_o,
    input wire logic [7:0] rd_data_i,
    input wire logic rd_err_i
);
    logic aw_full_r;
    logic w_full_r;
    logic [3:0] wstrb_r;

    // ------------------------------------------------------------
    // Write channel capture, address and data in either order
    // ------------------------------------------------------------
    assign s_awready_o = !aw_full_r;
    assign s_wready_o = !w_full_r;
    // Byte lane 0 carries all register bits; other lanes are ignored
    assign wr_o = aw_full_r && w_full_r && !s_bvalid_o && wstrb_r[0];

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            wr_addr_o <= 8'h00;
            wr_data_o <= 8'h00;
            wstrb_r <= 4'h0;
        end else begin
            if (s_awvalid_i && s_awready_o) begin
                aw_full_r <= 1'b1;
                wr_addr_o <= s_awaddr_i;
            end else if (aw_full_r && w_full_r && !s_bvalid_o) begin
                aw_full_r <= 1'b0;
            end
            if (s_wvalid_i && s_wready_o) begin
                w_full_r <= 1'b1;
                wr_data_o <= s_wdata_i[7:0];
                wstrb_r <= s_wstrb_i;
            end else if (aw_full_r && w_full_r && !s_bvalid_o) begin
                w_full_r <= 1'b0;
            end
        end
    end

    // Write response one cycle after both halves are held
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_bvalid_o <= 1'b0;
            s_bresp_o <= SLCD_RESP_OKAY;
        end else if (aw_full_r && w_full_r && !s_bvalid_o) begin
            s_bvalid_o <= 1'b1;
            s_bresp_o <= wr_err_i ? SLCD_RESP_SLVERR : SLCD_RESP_OKAY;
        end else if (s_bready_i) begin
            s_bvalid_o <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Read channel: data sampled at the address handshake
    // ------------------------------------------------------------
    assign s_arready_o = !s_rvalid_o;
    assign rd_addr_o = s_araddr_i;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_rvalid_o <= 1'b0;
            s_rdata_o <= 32'h0000_0000;
            s_rresp_o <= SLCD_RESP_OKAY;
        end else if (s_arvalid_i && s_arready_o) begin
            s_rvalid_o <= 1'b1;
            s_rdata_o <= {24'h00_0000, rd_data_i};
            s_rresp_o <= rd_err_i ? SLCD_RESP_SLVERR : SLCD_RESP_OKAY;
        end else if (s_rready_i) begin
            s_rvalid_o <= 1'b0;
        end
    end

    AST_BRESP_SOON: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (aw_full_r && w_full_r && !s_bvalid_o) |=> s_bvalid_o)
        else $error("write response missing");
    AST_BHOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (s_bvalid_o && !s_bready_i) |=> (s_bvalid_o && $stable(s_bresp_o)))
        else $error("write response dropped early");
    AST_RVALID: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (s_arvalid_i && s_arready_o) |=> (s_rvalid_o && !s_arready_o))
        else $error("read answer missing");
endmodule
`default_nettype wire

// File: verilog/slcd_top.sv
// What this block does
// RULE_01 - Twenty display bytes sit at window addresses 80H to 93H.
// RULE_02 - Window accesses reach display memory only while high pointer equals 01H.
// RULE_03 - Any other high pointer value sends window accesses to general memory.
// RULE_04 - Display memory is reached only indirectly through the low/high pointer pair.
// RULE_05 - Driver fetches display memory by itself and follows the latest written data.
// RULE_06 - A stored one lights its element, a stored zero blanks it.
// RULE_07 - Twenty segment outputs with four or eight commons, by duty.
// RULE_08 - Display timing runs from the low-speed sub clock.
// RULE_09 - Control 0 bit 7 enables the driver; reset leaves it off.
// RULE_10 - Control 0 bit 6 picks waveform A (0) or B (1).
// RULE_11 - Duty bit 0 uses commons 0-3; 1 uses commons 0-7.
// RULE_12 - Control 0 bit 4 picks one-third (0) or one-quarter (1) bias.
// RULE_13 - Each common change selects the low resistor, then returns to the high one.
// RULE_14 - Quick charge lasts field plus one sub clock periods.
// RULE_15 - Voltage code 0-7 gives (8+code)/16 supply; 8 and above full supply.
// RULE_16 - Unimplemented control bits read zero and ignore writes.
// RULE_17 - Software must not run driver and converter together on a shared pin.
// RULE_18 - Bias resistor select bits are stored and read back as written.
// RULE_19 - Quick charge timer restarts at each common change and then drops.
//
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
`include "slcd_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module slcd_top import slcd_pkg::*; #(
    parameter int COM_TICKS = `SLCD_COM_TICKS
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic sub_clk_i,
    input wire logic [7:0] s_awaddr_i,
    input wire logic s_awvalid_i,
    output logic s_awready_o,
    input wire logic [31:0] s_wdata_i,
    input wire logic [3:0] s_wstrb_i,
    input wire logic s_wvalid_i,
    output logic s_wready_o,
    output logic [1:0] s_bresp_o,
    output logic s_bvalid_o,
    input wire logic s_bready_i,
    input wire logic [7:0] s_araddr_i,
    input wire logic s_arvalid_i,
    output logic s_arready_o,
    output logic [31:0] s_rdata_o,
    output logic [1:0] s_rresp_o,
    output logic s_rvalid_o,
    input wire logic s_rready_i,
    output logic [19:0] seg_on_o,
    output logic [7:0] common_lines_o,
    output logic [7:0] common_panel_o,
    output logic drive_neg_o,
    output logic wave_type_b_o,
    output logic bias_quarter_o,
    output logic quick_charge_o,
    output logic [2:0] bias_resistor_select_o,
    output logic [4:0] panel_voltage_level_o
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [7:0] panel_control_0_r;
    logic [7:0] panel_control_1_r;
    logic [7:0] mem_pointer_high_r;
    logic [7:0] mem_pointer_low_r;
    logic [7:0] disp_mem [0:`SLCD_SEG_NUM-1];
    logic [7:0] gp_mem [0:`SLCD_SEG_NUM-1];
    logic wr;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic wr_err;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    logic rd_err;
    logic sub_s;
    logic sub_prev_r;
    logic sub_tick;
    logic [7:0] tick_cnt_r;
    logic [2:0] com_idx_r;
    logic [2:0] com_idx_nxt;
    logic com_step;
    logic frame_neg_r;
    logic [3:0] qc_cnt_r;
    logic panel_driver_on;
    logic duty_select;
    logic [2:0] quick_charge_time;
    logic [3:0] panel_voltage_level;
    logic win_hit;
    logic disp_sel;
    logic [4:0] win_idx;
    logic disp_wr_hit;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Window test, used for both indirect read and write paths
    function automatic logic in_window(input logic [7:0] a);
        in_window = (a >= `SLCD_WIN_FIRST) && (a <= `SLCD_WIN_LAST); // [RULE_01]
    endfunction

    assign panel_driver_on = panel_control_0_r[`SLCD_C0_EN];
    assign duty_select = panel_control_0_r[`SLCD_C0_DUTY];
    assign quick_charge_time = panel_control_1_r[`SLCD_C1_QCT_LSB +: 3];
    assign panel_voltage_level = panel_control_1_r[`SLCD_C1_VLCD_MSB:0];

    // Pointer pair selects target; direct addresses never reach the window
    assign win_hit = in_window(mem_pointer_low_r); // [RULE_04]
    assign disp_sel = (mem_pointer_high_r == `SLCD_PTRH_DISP); // [RULE_02] [RULE_03]
    assign win_idx = 5'(mem_pointer_low_r - `SLCD_WIN_FIRST);
    assign disp_wr_hit = wr && (wr_addr == `SLCD_ADDR_DATA) && win_hit && disp_sel;

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    slcd_axil u_axil (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .s_awaddr_i(s_awaddr_i),
        .s_awvalid_i(s_awvalid_i),
        .s_awready_o(s_awready_o),
        .s_wdata_i(s_wdata_i),
        .s_wstrb_i(s_wstrb_i),
        .s_wvalid_i(s_wvalid_i),
        .s_wready_o(s_wready_o),
        .s_bresp_o(s_bresp_o),
        .s_bvalid_o(s_bvalid_o),
        .s_bready_i(s_bready_i),
        .s_araddr_i(s_araddr_i),
        .s_arvalid_i(s_arvalid_i),
        .s_arready_o(s_arready_o),
        .s_rdata_o(s_rdata_o),
        .s_rresp_o(s_rresp_o),
        .s_rvalid_o(s_rvalid_o),
        .s_rready_i(s_rready_i),
        .wr_o(wr),
        .wr_addr_o(wr_addr),
        .wr_data_o(wr_data),
        .wr_err_i(wr_err),
        .rd_addr_o(rd_addr),
        .rd_data_i(rd_data),
        .rd_err_i(rd_err)
    );

    // Unmapped offsets answer with a slave error
    assign wr_err = !((wr_addr == `SLCD_ADDR_CTRL0) || (wr_addr == `SLCD_ADDR_CTRL1) ||
        (wr_addr == `SLCD_ADDR_PTRH) || (wr_addr == `SLCD_ADDR_PTRL) ||
        (wr_addr == `SLCD_ADDR_DATA) || (wr_addr == `SLCD_ADDR_STAT));

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    // Masks keep unimplemented bits at zero whatever is written
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            panel_control_0_r <= `SLCD_CTRL0_RST; // [RULE_09]
            panel_control_1_r <= `SLCD_CTRL1_RST;
        end else if (wr) begin
            if (wr_addr == `SLCD_ADDR_CTRL0) begin
                panel_control_0_r <= wr_data & `SLCD_CTRL0_MASK; // [RULE_16] [RULE_18]
            end else if (wr_addr == `SLCD_ADDR_CTRL1) begin
                panel_control_1_r <= wr_data & `SLCD_CTRL1_MASK & `SLCD_CTRL1_WMASK; // [RULE_16]
            end
        end
    end

    // Pointer pair
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mem_pointer_high_r <= 8'h00;
            mem_pointer_low_r <= 8'h00;
        end else if (wr) begin
            if (wr_addr == `SLCD_ADDR_PTRH) begin
                mem_pointer_high_r <= wr_data;
            end else if (wr_addr == `SLCD_ADDR_PTRL) begin
                mem_pointer_low_r <= wr_data;
            end
        end
    end

    // Indirect writes land in display or general memory by high pointer
    always_ff @(posedge clk_i) begin
        if (disp_wr_hit) begin
            disp_mem[win_idx] <= wr_data; // [RULE_02]
        end else if (wr && (wr_addr == `SLCD_ADDR_DATA) && win_hit) begin
            gp_mem[win_idx] <= wr_data; // [RULE_03]
        end
    end

    // ------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------
    always_comb begin
        rd_data = 8'h00;
        rd_err = 1'b0;
        if (rd_addr == `SLCD_ADDR_CTRL0) begin
            rd_data = panel_control_0_r;
        end else if (rd_addr == `SLCD_ADDR_CTRL1) begin
            rd_data = panel_control_1_r;
        end else if (rd_addr == `SLCD_ADDR_PTRH) begin
            rd_data = mem_pointer_high_r;
        end else if (rd_addr == `SLCD_ADDR_PTRL) begin
            rd_data = mem_pointer_low_r;
        end else if (rd_addr == `SLCD_ADDR_DATA) begin
            if (win_hit) begin
                rd_data = disp_sel ? disp_mem[win_idx] : gp_mem[win_idx]; // [RULE_04]
            end
        end else if (rd_addr == `SLCD_ADDR_STAT) begin
            rd_data = {3'h0, quick_charge_o, frame_neg_r, com_idx_r};
        end else begin
            rd_err = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Sub clock edge detect
    // ------------------------------------------------------------
    // Sub clock is far slower than clk_i, so sampling it is safe
    slcd_sync u_sub_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .async_i(sub_clk_i),
        .sync_o(sub_s)
    );

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sub_prev_r <= 1'b0;
        end else begin
            sub_prev_r <= sub_s;
        end
    end
    assign sub_tick = sub_s && !sub_prev_r; // [RULE_08]

    // ------------------------------------------------------------
    // Common scan
    // ------------------------------------------------------------
    assign com_step = panel_driver_on && sub_tick &&
        (tick_cnt_r == 8'(COM_TICKS - 1));
    // Wrap after common 3 or 7 depending on duty
    assign com_idx_nxt = (!duty_select && (com_idx_r >= 3'h3)) ? 3'h0 :
        3'(com_idx_r + 3'h1); // [RULE_11]

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tick_cnt_r <= 8'h00;
            com_idx_r <= 3'h0;
            frame_neg_r <= 1'b0;
        end else if (!panel_driver_on) begin
            tick_cnt_r <= 8'h00;
            com_idx_r <= 3'h0;
            frame_neg_r <= 1'b0;
        end else if (com_step) begin
            tick_cnt_r <= 8'h00;
            com_idx_r <= com_idx_nxt;
            if (com_idx_nxt == 3'h0) begin
                frame_neg_r <= !frame_neg_r;
            end
        end else if (sub_tick) begin
            tick_cnt_r <= 8'(tick_cnt_r + 8'h01);
        end
    end

    // ------------------------------------------------------------
    // Quick charge timer
    // ------------------------------------------------------------
    // Reloaded on every common change so the low resistor covers each edge
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            qc_cnt_r <= 4'h0;
        end else if (!panel_driver_on) begin
            qc_cnt_r <= 4'h0;
        end else if (com_step) begin
            qc_cnt_r <= {1'b0, quick_charge_time} + 4'h1; // [RULE_13] [RULE_14] [RULE_19]
        end else if (sub_tick && (qc_cnt_r != 4'h0)) begin
            qc_cnt_r <= 4'(qc_cnt_r - 4'h1); // [RULE_19]
        end
    end

    // ------------------------------------------------------------
    // Panel drive outputs
    // ------------------------------------------------------------
    // Segment data refetched every cycle, so new writes show at once
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            seg_on_o <= 20'h0_0000;
            common_lines_o <= 8'h00;
            common_panel_o <= 8'h00;
            drive_neg_o <= 1'b0;
        end else begin
            for (int s = 0; s < `SLCD_SEG_NUM; s++) begin
                seg_on_o[s] <= panel_driver_on && disp_mem[s][com_idx_r]; // [RULE_05] [RULE_06]
            end
            common_lines_o <= (panel_driver_on && (duty_select || !com_idx_r[2])) ?
                (8'h01 << com_idx_r) : 8'h00; // [RULE_07] [RULE_11]
            common_panel_o <= !panel_driver_on ? 8'h00 :
                (duty_select ? 8'hFF : 8'h0F); // [RULE_11]
            // Type A flips mid slot, type B flips once per frame
            drive_neg_o <= panel_control_0_r[`SLCD_C0_TYPE] ? frame_neg_r :
                (tick_cnt_r >= 8'(COM_TICKS / 2)); // [RULE_10]
        end
    end

    // Mode, level and quick charge outputs
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wave_type_b_o <= 1'b0;
            bias_quarter_o <= 1'b0;
            quick_charge_o <= 1'b0;
            bias_resistor_select_o <= 3'h0;
            panel_voltage_level_o <= `SLCD_VLCD_BASE;
        end else begin
            wave_type_b_o <= panel_control_0_r[`SLCD_C0_TYPE]; // [RULE_10]
            bias_quarter_o <= panel_control_0_r[`SLCD_C0_BIAS]; // [RULE_12]
            quick_charge_o <= panel_driver_on && (qc_cnt_r != 4'h0); // [RULE_13]
            bias_resistor_select_o <= panel_control_0_r[2:0]; // [RULE_18]
            panel_voltage_level_o <= panel_voltage_level[3] ? `SLCD_VLCD_FULL :
                (`SLCD_VLCD_BASE + {2'h0, panel_voltage_level[2:0]}); // [RULE_15]
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_QC_LOAD: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE_14]
        com_step |=> (qc_cnt_r == {1'b0, $past(quick_charge_time)} + 4'h1) ##1 quick_charge_o)
        else $error("quick charge length wrong");
    AST_QC_DROP: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE_19]
        (sub_tick && qc_cnt_r == 4'h1 && !com_step) |=> ##1 !quick_charge_o)
        else $error("quick charge did not end");
    AST_DUTY4: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE_11]
        (!duty_select && !$past(duty_select)) |=> (common_lines_o[7:4] == 4'h0))
        else $error("upper commons active at quarter duty");
    AST_OFF: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE_09]
        !panel_driver_on |=> (seg_on_o == 20'h0_0000 && common_lines_o == 8'h00))
        else $error("panel driven while disabled");
    AST_VLCD: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE_15]
        ##1 panel_voltage_level_o == ($past(panel_voltage_level[3]) ? 5'h10 :
            5'(5'h08 + $past(panel_voltage_level[2:0]))))
        else $error("panel voltage code wrong");
    AST_RSV_ZERO: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE_16]
        (panel_control_0_r[3] == 1'b0 && panel_control_1_r[4] == 1'b0))
        else $error("unimplemented bit set");
    AST_DISP_GATE: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE_02]
        (wr && wr_addr == `SLCD_ADDR_DATA && win_hit && !disp_sel) |=> $stable(disp_mem[win_idx]))
        else $error("display written with wrong pointer");
endmodule
`default_nettype wire

// File: dv/slcd_panel_model.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------
// Glass model: keeps lit pattern per common
// ------------------------------------------------
module slcd_panel_model (
    input wire logic clk_i,
    input wire logic sub_clk_i,
    input wire logic [19:0] seg_i,
    input wire logic [7:0] com_i,
    input wire logic qc_i
);
    logic [19:0] img [8];
    logic [3:0] qc_cnt = 4'h0;
    logic [3:0] qc_len = 4'h0;
    logic sub_d = 1'b0;
    // Element lit while its common is active
    always_ff @(posedge clk_i) begin
        for (int c = 0; c < 8; c++) begin
            if (com_i[c]) img[c] <= seg_i;
        end
    end
    // Low-resistor time in sub periods; raw edges, not the synchronised ones
    always_ff @(posedge clk_i) begin
        sub_d <= sub_clk_i;
        if (qc_i && sub_clk_i && !sub_d) qc_cnt <= qc_cnt + 4'h1;
        if (!qc_i && qc_cnt != 4'h0) begin
            qc_len <= qc_cnt;
            qc_cnt <= 4'h0;
        end
    end
endmodule
`default_nettype wire

// File: dv/slcd_top_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "slcd_defs.svh"
module slcd_top_tb_top;
    localparam int FRAME = 8 * 10 * 25;
    logic clk_i = 0, rst_n_i = 0, sub_clk_i = 0, s_awvalid_i = 0, s_wvalid_i = 0, s_arvalid_i = 0;
    logic s_bready_i = 1, s_rready_i = 1;
    logic [3:0] s_wstrb_i = 4'hF;
    logic [7:0] s_awaddr_i = 0, s_araddr_i = 0, v;
    logic [31:0] s_wdata_i = 0, s_rdata_o, rd;
    logic s_awready_o, s_wready_o, s_bvalid_o, s_arready_o, s_rvalid_o, drive_neg_o;
    logic wave_type_b_o, bias_quarter_o, quick_charge_o;
    logic [1:0] s_bresp_o, s_rresp_o, rs;
    logic [19:0] seg_on_o;
    logic [7:0] common_lines_o, common_panel_o, mem [20];
    logic [2:0] bias_resistor_select_o, qct;
    logic [4:0] panel_voltage_level_o;
    int miscompares = 0, n_compared = 0, cyc = 0;
    slcd_top #(.COM_TICKS(10)) slcd_top_i (.clk_i, .rst_n_i, .sub_clk_i, .s_awaddr_i,
        .s_awvalid_i, .s_awready_o, .s_wdata_i, .s_wstrb_i, .s_wvalid_i, .s_wready_o,
        .s_bresp_o, .s_bvalid_o, .s_bready_i, .s_araddr_i, .s_arvalid_i, .s_arready_o,
        .s_rdata_o, .s_rresp_o, .s_rvalid_o, .s_rready_i, .seg_on_o, .common_lines_o,
        .common_panel_o, .drive_neg_o, .wave_type_b_o, .bias_quarter_o, .quick_charge_o,
        .bias_resistor_select_o, .panel_voltage_level_o);
    slcd_panel_model slcd_panel_model_i (.clk_i, .sub_clk_i, .seg_i(seg_on_o),
        .com_i(common_lines_o), .qc_i(quick_charge_o));
    // ------------------------------------------------
    // Clocks, watchdog and bus tasks
    // ------------------------------------------------
    initial forever #20 clk_i = ~clk_i;
    initial begin
        #7;
        forever #500 sub_clk_i = ~sub_clk_i;
    end
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 60000) begin
            miscompares++;
            print_verdict();
        end
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task print_verdict;
        $display("compared=%0d miscompares=%0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Handshakes judged at the negedge before the deciding rising edge
    task wr(input logic [7:0] a, input logic [7:0] d);
        logic ha, hw, hb;
        s_awaddr_i <= a;
        s_wdata_i <= {24'h0, d};
        s_awvalid_i <= 1'b1;
        s_wvalid_i <= 1'b1;
        do begin
            @(negedge clk_i);
            ha = s_awvalid_i && s_awready_o;
            hw = s_wvalid_i && s_wready_o;
            hb = s_bvalid_o;
            rs = s_bresp_o;
            @(posedge clk_i);
            if (ha) s_awvalid_i <= 1'b0;
            if (hw) s_wvalid_i <= 1'b0;
        end while (!hb);
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] exp);
        logic ha, hr;
        s_araddr_i <= a;
        s_arvalid_i <= 1'b1;
        do begin
            @(negedge clk_i);
            ha = s_arvalid_i && s_arready_o;
            hr = s_rvalid_o;
            rd = s_rdata_o;
            rs = s_rresp_o;
            @(posedge clk_i);
            if (ha) s_arvalid_i <= 1'b0;
        end while (!hr);
        chk(rd, exp);
    endtask
    function automatic logic [19:0] img(input int c);
        for (int s = 0; s < 20; s++) img[s] = mem[s][c];
    endfunction
    // Main sequence; the converter is never enabled beside the driver
    initial begin
        void'($urandom(22947));
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        rchk(`SLCD_ADDR_CTRL0, 0);
        rchk(`SLCD_ADDR_CTRL1, 0);
        chk(32'(panel_voltage_level_o), 8);
        for (int i = 0; i < 16; i++) begin
            v = 8'($urandom) & 8'h7F;
            wr(`SLCD_ADDR_CTRL0, v | 8'h08);
            rchk(`SLCD_ADDR_CTRL0, 32'(v & 8'h77));
            chk({wave_type_b_o, bias_quarter_o, bias_resistor_select_o}, {v[6], v[4], v[2:0]});
            v = {3'($urandom), 1'b1, 4'(i)};
            wr(`SLCD_ADDR_CTRL1, v);
            rchk(`SLCD_ADDR_CTRL1, 32'(v & 8'hEF));
            chk(32'(panel_voltage_level_o), i < 8 ? 8 + i : 16);
        end
        s_wstrb_i <= 4'hE;
        wr(`SLCD_ADDR_PTRL, 8'h81);
        s_wstrb_i <= 4'hF;
        rchk(`SLCD_ADDR_PTRL, 0);
        wr(8'h18, 0);
        chk(32'(rs), 2);
        $display("test registers done");
        rchk(8'h80, 0);
        chk(32'(rs), 32'(slcd_pkg::SLCD_RESP_SLVERR));
        for (int p = 0; p < 3; p++) begin
            wr(`SLCD_ADDR_PTRH, p == 1 ? 8'h02 : 8'h01);
            for (int s = 0; s < 20; s++) begin
                wr(`SLCD_ADDR_PTRL, 8'(8'h80 + s));
                if (p == 0) mem[s] = 8'($urandom);
                v = p == 1 ? ~mem[s] : mem[s];
                if (p < 2) wr(`SLCD_ADDR_DATA, v);
                rchk(`SLCD_ADDR_DATA, 32'(v));
            end
        end
        wr(`SLCD_ADDR_PTRL, 8'h94);
        rchk(`SLCD_ADDR_DATA, 0);
        $display("test memory done");
        for (int d = 0; d < 2; d++) begin
            qct = 3'($urandom);
            mem[19] = 8'($urandom);
            wr(`SLCD_ADDR_PTRL, 8'h93);
            wr(`SLCD_ADDR_DATA, mem[19]);
            wr(`SLCD_ADDR_CTRL1, {qct, 5'h03});
            wr(`SLCD_ADDR_CTRL0, d == 1 ? 8'hA0 : 8'h80);
            repeat (2 * FRAME) @(posedge clk_i);
            chk(32'(common_panel_o), d == 1 ? 32'hFF : 32'h0F);
            for (int c = 0; c < 4 + 4 * d; c++) chk(slcd_panel_model_i.img[c], img(c));
            chk(32'(slcd_panel_model_i.qc_len), qct + 1);
        end
        wr(`SLCD_ADDR_CTRL0, 8'h00);
        rchk(`SLCD_ADDR_STAT, 0);
        chk({drive_neg_o, quick_charge_o, common_lines_o, seg_on_o}, 0);
        $display("test panel done");
        print_verdict();
    end
endmodule
`default_nettype wire
